//--- rtl/rsx_pkg.sv
package rsx_pkg;
    // ==========================================
    // register map
    localparam logic [5:0] ADDR_CLEAR_CHANNEL_AND_EXIT_CONFIG = 6'h16;
    localparam logic [5:0] ADDR_CALIBRATION_AND_POWER_CONFIG = 6'h17;
    localparam logic [7:0] RST_CLEAR_CHANNEL_AND_EXIT_CONFIG = 8'h30;
    localparam logic [7:0] RST_CALIBRATION_AND_POWER_CONFIG = 8'h00;
    localparam logic [7:0] CFG_USED_MASK = 8'h3f;
    localparam int MODE_HI = 5;
    localparam int MODE_LO = 4;
    localparam int RXOFF_HI = 3;
    localparam int RXOFF_LO = 2;
    localparam int TXOFF_HI = 1;
    localparam int TXOFF_LO = 0;
    localparam logic [1:0] AUTOCAL_PERIOD_M1 = 2'h3;

    // ==========================================
    // types
    typedef enum logic [2:0] {
        RSX_IDLE = 3'b000,
        RSX_RX = 3'b001,
        RSX_TX = 3'b010,
        RSX_FSTX = 3'b011,
        RSX_CAL = 3'b100
    } rsx_state_e;

    typedef struct packed {
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rsx_reg_req_s;

    typedef struct packed {
        logic go_rx;
        logic go_tx;
        logic go_fstx;
        logic go_idle;
        logic rx_done;
        logic tx_done;
        logic cal_strobe;
        logic cal_done;
    } rsx_cmd_s;
endpackage

//--- rtl/rsx_radio_state_exit_config.sv
// How it works
// - clear-channel mode in bits 5:4 of first config register, resets to 11
// - clear-channel output: always, rssi low, not receiving, or both
// - after receive go to idle, fstx, tx or stay rx per bits 3:2
// - after transmit go to idle, fstx, stay tx or rx per bits 1:0
// - staying in tx restarts preamble right away
// - autocal policy bits 5:4 of second config register: never, leave, return
// - policy never: calibrate only on the host calibrate strobe
// - policy 3: calibrate on every fourth rx/tx to idle return
module rsx_radio_state_exit_config (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire rsx_pkg::rsx_reg_req_s req_i,
    input wire rsx_pkg::rsx_cmd_s cmd_i,
    input wire logic rssi_below_thr_i,
    input wire logic pkt_receiving_i,
    output logic [7:0] rdata_o,
    output logic clear_channel_signal_o,
    output rsx_pkg::rsx_state_e state_o,
    output logic synth_cal_busy_o,
    output logic preamble_restart_o
);
    // ==========================================
    // configuration registers
    logic [7:0] cfg2_q, cfg2_d, cfg1_q, cfg1_d, rdata_q, rdata_d;
    always_comb begin
        cfg2_d = cfg2_q;
        cfg1_d = cfg1_q;
        if (req_i.wr && req_i.addr == rsx_pkg::ADDR_CLEAR_CHANNEL_AND_EXIT_CONFIG) begin
            cfg2_d = req_i.wdata & rsx_pkg::CFG_USED_MASK;
        end
        if (req_i.wr && req_i.addr == rsx_pkg::ADDR_CALIBRATION_AND_POWER_CONFIG) begin
            cfg1_d = req_i.wdata & rsx_pkg::CFG_USED_MASK;
        end
        // read data registered; unmapped addresses read zero
        case (req_i.addr)
            rsx_pkg::ADDR_CLEAR_CHANNEL_AND_EXIT_CONFIG: rdata_d = cfg2_q;
            rsx_pkg::ADDR_CALIBRATION_AND_POWER_CONFIG: rdata_d = cfg1_q;
            default: rdata_d = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg2_q <= rsx_pkg::RST_CLEAR_CHANNEL_AND_EXIT_CONFIG;
            cfg1_q <= rsx_pkg::RST_CALIBRATION_AND_POWER_CONFIG;
            rdata_q <= 8'h00;
        end else begin
            cfg2_q <= cfg2_d;
            cfg1_q <= cfg1_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata_o = rdata_q;

    // ==========================================
    // clear-channel indication
    logic cc_q, cc_d;
    always_comb begin
        case (cfg2_q[rsx_pkg::MODE_HI:rsx_pkg::MODE_LO])
            2'h0: cc_d = 1'b1;
            2'h1: cc_d = rssi_below_thr_i;
            2'h2: cc_d = !pkt_receiving_i;
            default: cc_d = rssi_below_thr_i && !pkt_receiving_i;
        endcase
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) cc_q <= 1'b0;
        else cc_q <= cc_d;
    end
    assign clear_channel_signal_o = cc_q;

    // ==========================================
    // radio state and calibration
    rsx_pkg::rsx_state_e st_q, st_d, after_cal_q, after_cal_d;
    logic [1:0] ret_cnt_q, ret_cnt_d;
    logic pre_q, pre_d;
    logic busy_q, busy_d;
    logic [1:0] pol;
    assign pol = cfg1_q[rsx_pkg::MODE_HI:rsx_pkg::MODE_LO];

    // shared exit decode: 0 idle, 1 fstx, 2 tx, 3 rx
    function automatic rsx_pkg::rsx_state_e exit_state(input logic [1:0] f);
        case (f)
            2'h0: exit_state = rsx_pkg::RSX_IDLE;
            2'h1: exit_state = rsx_pkg::RSX_FSTX;
            2'h2: exit_state = rsx_pkg::RSX_TX;
            default: exit_state = rsx_pkg::RSX_RX;
        endcase
    endfunction

    always_comb begin
        rsx_pkg::rsx_state_e tgt;
        logic returning;
        tgt = st_q;
        returning = 1'b0;
        st_d = st_q;
        after_cal_d = after_cal_q;
        ret_cnt_d = ret_cnt_q;
        pre_d = 1'b0;
        case (st_q)
            rsx_pkg::RSX_IDLE: begin
                if (cmd_i.go_rx) tgt = rsx_pkg::RSX_RX;
                else if (cmd_i.go_tx) tgt = rsx_pkg::RSX_TX;
                else if (cmd_i.go_fstx) tgt = rsx_pkg::RSX_FSTX;
                // manual calibration strobe, honoured under any policy
                if (cmd_i.cal_strobe) begin
                    st_d = rsx_pkg::RSX_CAL;
                    after_cal_d = rsx_pkg::RSX_IDLE;
                end else if (tgt != rsx_pkg::RSX_IDLE) begin
                    // calibrate on leaving idle with policy 1
                    if (pol == 2'h1) begin
                        st_d = rsx_pkg::RSX_CAL;
                        after_cal_d = tgt;
                    end else st_d = tgt;
                end
            end
            rsx_pkg::RSX_RX: begin
                // exit after receive; tx/fstx with cca is host's to avoid
                if (cmd_i.rx_done) tgt = exit_state(cfg2_q[rsx_pkg::RXOFF_HI:rsx_pkg::RXOFF_LO]);
                else if (cmd_i.go_idle) tgt = rsx_pkg::RSX_IDLE;
                else if (cmd_i.go_tx) tgt = rsx_pkg::RSX_TX;
                returning = (tgt == rsx_pkg::RSX_IDLE);
                if (!returning) st_d = tgt;
            end
            rsx_pkg::RSX_TX: begin
                if (cmd_i.tx_done) tgt = exit_state(cfg2_q[rsx_pkg::TXOFF_HI:rsx_pkg::TXOFF_LO]);
                else if (cmd_i.go_idle) tgt = rsx_pkg::RSX_IDLE;
                else if (cmd_i.go_rx) tgt = rsx_pkg::RSX_RX;
                // stay in tx and resend preamble
                pre_d = cmd_i.tx_done && (tgt == rsx_pkg::RSX_TX);
                returning = (tgt == rsx_pkg::RSX_IDLE);
                if (!returning) st_d = tgt;
            end
            rsx_pkg::RSX_FSTX: begin
                if (cmd_i.go_tx) st_d = rsx_pkg::RSX_TX;
                else if (cmd_i.go_rx) st_d = rsx_pkg::RSX_RX;
                else if (cmd_i.go_idle) st_d = rsx_pkg::RSX_IDLE;
            end
            rsx_pkg::RSX_CAL: begin
                if (cmd_i.cal_done) st_d = after_cal_q;
            end
            default: st_d = rsx_pkg::RSX_IDLE;
        endcase
        if (returning) begin
            st_d = rsx_pkg::RSX_IDLE;
            after_cal_d = rsx_pkg::RSX_IDLE;
            // calibrate on return with policy 2
            if (pol == 2'h2) st_d = rsx_pkg::RSX_CAL;
            // every fourth return with policy 3
            if (pol == 2'h3) begin
                ret_cnt_d = ret_cnt_q + 2'h1;
                if (ret_cnt_q == rsx_pkg::AUTOCAL_PERIOD_M1) st_d = rsx_pkg::RSX_CAL;
            end
        end
        // busy kept in its own flop so the pin is glitch free, same timing as state
        busy_d = (st_d == rsx_pkg::RSX_CAL);
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= rsx_pkg::RSX_IDLE;
            after_cal_q <= rsx_pkg::RSX_IDLE;
            ret_cnt_q <= 2'h0;
            pre_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            after_cal_q <= after_cal_d;
            ret_cnt_q <= ret_cnt_d;
            pre_q <= pre_d;
            busy_q <= busy_d;
        end
    end
    assign state_o = st_q;
    assign synth_cal_busy_o = busy_q;
    assign preamble_restart_o = pre_q;

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_unused_bits_zero: assert property (cfg2_q[7:6] == 2'h0 && cfg1_q[7:6] == 2'h0)
        else $error("unused config bits not zero");
    a_cc_mode_both: assert property (cfg2_q[5:4] == 2'h3 && !rssi_below_thr_i ##1 1'b1
        |-> !clear_channel_signal_o)
        else $error("clear channel wrong in mode 3");
    a_cc_mode_always: assert property (cfg2_q[5:4] == 2'h0 |=> clear_channel_signal_o)
        else $error("clear channel not always in mode 0");
    a_rx_exit_state: assert property (st_q == rsx_pkg::RSX_RX && cmd_i.rx_done
        && cfg2_q[3:2] == 2'h3 |=> st_q == rsx_pkg::RSX_RX)
        else $error("rx exit did not stay in rx");
    a_tx_exit_rx: assert property (st_q == rsx_pkg::RSX_TX && cmd_i.tx_done
        && cfg2_q[1:0] == 2'h3 |=> st_q == rsx_pkg::RSX_RX)
        else $error("tx exit did not go to rx");
    a_tx_stay_pre: assert property (st_q == rsx_pkg::RSX_TX && cmd_i.tx_done
        && cfg2_q[1:0] == 2'h2 |=> preamble_restart_o && st_q == rsx_pkg::RSX_TX)
        else $error("preamble not restarted");
    a_never_no_autocal: assert property (pol == 2'h0 && st_q != rsx_pkg::RSX_CAL
        && !cmd_i.cal_strobe |=> !synth_cal_busy_o)
        else $error("autocal under policy never");
    a_leave_idle_cal: assert property (st_q == rsx_pkg::RSX_IDLE && pol == 2'h1
        && cmd_i.go_rx && !cmd_i.cal_strobe |=> synth_cal_busy_o)
        else $error("no cal on leaving idle");
    a_fourth_return: assert property (pol == 2'h3 && ret_cnt_q != 2'h3
        && st_q != rsx_pkg::RSX_CAL && !cmd_i.cal_strobe |=> !synth_cal_busy_o)
        else $error("cal before fourth return");
    a_fourth_cal: assert property (pol == 2'h3 && ret_cnt_q == 2'h3 && st_q == rsx_pkg::RSX_RX
        && cmd_i.go_idle && !cmd_i.rx_done |=> synth_cal_busy_o)
        else $error("no cal on fourth return");
    a_cc_mode_rssi: assert property (cfg2_q[5:4] == 2'h1
        |=> clear_channel_signal_o == $past(rssi_below_thr_i))
        else $error("clear channel wrong in mode 1");
    a_cc_mode_recv: assert property (cfg2_q[5:4] == 2'h2
        |=> clear_channel_signal_o == !$past(pkt_receiving_i))
        else $error("clear channel wrong in mode 2");
    a_return_cal: assert property (pol == 2'h2 && st_q == rsx_pkg::RSX_TX && cmd_i.go_idle
        && !cmd_i.tx_done |=> synth_cal_busy_o)
        else $error("no cal on return to idle");
    a_leave_fstx_cal: assert property (st_q == rsx_pkg::RSX_IDLE && pol == 2'h1
        && cmd_i.go_fstx && !cmd_i.go_rx && !cmd_i.go_tx && !cmd_i.cal_strobe |=> synth_cal_busy_o)
        else $error("no cal on leaving idle for fstx");
endmodule

//--- tb/rsx_host_model.sv
module rsx_host_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] rdata_i,
    output rsx_pkg::rsx_reg_req_s req_o,
    output rsx_pkg::rsx_cmd_s cmd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req_o = '0;
        cmd_o = '0;
    end
    // ==========================================
    // register bus, one byte per write
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b1, addr: a, wdata: d};
        @(negedge ref_clk_i);
        req_o.wr = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        req_o.addr = a;
        @(negedge ref_clk_i);
        d = rdata_i;
    endtask
    // one-cycle command pulse, any cmd field
    // one-cycle pulse; with policy never, the host calibrates through cal_strobe
    task automatic pulse(input rsx_pkg::rsx_cmd_s c);
        @(negedge ref_clk_i);
        cmd_o = c;
        @(negedge ref_clk_i);
        cmd_o = '0;
    endtask
    // clear-channel mode both (3) when the rx exit is idle or stay in rx
    // rx exit to tx or fstx drops the clear-channel mode to always
    task automatic set_exits(input logic [1:0] rxm, input logic [1:0] txm);
        wr(rsx_pkg::ADDR_CLEAR_CHANNEL_AND_EXIT_CONFIG,
           {2'h0, (rxm == 2'h1 || rxm == 2'h2) ? 2'h0 : 2'h3, rxm, txm});
    endtask
endmodule

//--- tb/rsx_radio_state_exit_config_bench.sv
module rsx_radio_state_exit_config_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] A16 = rsx_pkg::ADDR_CLEAR_CHANNEL_AND_EXIT_CONFIG;
    localparam logic [5:0] A17 = rsx_pkg::ADDR_CALIBRATION_AND_POWER_CONFIG;
    localparam rsx_pkg::rsx_cmd_s C_RX = 8'h80;
    localparam rsx_pkg::rsx_cmd_s C_TX = 8'h40;
    localparam rsx_pkg::rsx_cmd_s C_FSTX = 8'h20;
    localparam rsx_pkg::rsx_cmd_s C_IDLE = 8'h10;
    localparam rsx_pkg::rsx_cmd_s C_RXD = 8'h08;
    localparam rsx_pkg::rsx_cmd_s C_TXD = 8'h04;
    localparam rsx_pkg::rsx_cmd_s C_CAL = 8'h02;
    localparam rsx_pkg::rsx_cmd_s C_CALD = 8'h01;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rssi_low = 1'b0;
    logic pkt_rx = 1'b0;
    logic [7:0] rdata;
    logic ccs;
    logic cal_busy;
    logic pre;
    logic [7:0] v;
    rsx_pkg::rsx_state_e state;
    rsx_pkg::rsx_reg_req_s req;
    rsx_pkg::rsx_cmd_s cmd;
    int miscompares = 0;
    int cmp_count = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    rsx_radio_state_exit_config dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req),
        .cmd_i(cmd), .rssi_below_thr_i(rssi_low), .pkt_receiving_i(pkt_rx), .rdata_o(rdata),
        .clear_channel_signal_o(ccs), .state_o(state), .synth_cal_busy_o(cal_busy),
        .preamble_restart_o(pre));
    rsx_host_model host_u (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req), .cmd_o(cmd));
    // ==========================================
    // checking
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic st(input logic [2:0] e);
        chk({5'h0, state}, {5'h0, e});
    endtask
    function automatic logic cc_exp(input logic [1:0] m, input logic r, input logic p);
        return (m == 2'h0) | (m == 2'h1 & r) | (m == 2'h2 & !p) | (m == 2'h3 & r & !p);
    endfunction
    // state codes: idle 0, rx 1, tx 2, fstx 3, cal 4
    function automatic logic [2:0] rx_next(input logic [1:0] m);
        return (m == 2'h0) ? 3'h0 : (m == 2'h1) ? 3'h3 : (m == 2'h2) ? 3'h2 : 3'h1;
    endfunction
    function automatic logic [2:0] tx_next(input logic [1:0] m);
        return (m == 2'h0) ? 3'h0 : (m == 2'h1) ? 3'h3 : (m == 2'h2) ? 3'h2 : 3'h1;
    endfunction
    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(95));
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        host_u.rd(A16, v);
        chk(v, 8'h30);
        host_u.rd(A17, v);
        chk(v, 8'h00);
        host_u.rd(6'h20, v);
        chk(v, 8'h00);
        host_u.wr(A16, 8'hff);
        host_u.rd(A16, v);
        chk(v, 8'h3f);
        host_u.wr(A17, 8'hc0);
        host_u.rd(A17, v);
        chk(v, 8'h00);
        for (int m = 0; m < 4; m++) begin
            host_u.wr(A16, {2'h0, m[1:0], 4'h0});
            repeat (6) begin
                @(negedge ref_clk_i);
                rssi_low = 1'($urandom);
                pkt_rx = 1'($urandom);
                @(negedge ref_clk_i);
                chk({7'h0, ccs}, {7'h0, cc_exp(m[1:0], rssi_low, pkt_rx)});
            end
        end
        for (int m = 0; m < 4; m++) begin
            host_u.set_exits(m[1:0], m[1:0]);
            host_u.pulse(C_RX);
            host_u.pulse(C_RXD);
            st(rx_next(m[1:0]));
            host_u.pulse(C_IDLE);
            host_u.pulse(C_TX);
            host_u.pulse(C_TXD);
            chk({7'h0, pre}, {7'h0, m == 2});
            st(tx_next(m[1:0]));
            host_u.pulse(C_IDLE);
        end
        // policy 3: a mix of rx_done and go_idle returns, cal on each fourth
        host_u.set_exits(2'h0, 2'h0);
        host_u.wr(A17, 8'h30);
        for (int i = 1; i <= 8; i++) begin
            host_u.pulse(C_RX);
            host_u.pulse(i[0] ? C_RXD : C_IDLE);
            st((i % 4 == 0) ? 3'h4 : 3'h0);
            host_u.pulse(C_CALD);
        end
        host_u.wr(A17, 8'h10);
        host_u.pulse(C_TX);
        chk({7'h0, cal_busy}, 8'h01);
        host_u.pulse(C_CALD);
        st(3'h2);
        host_u.pulse(C_IDLE);
        st(3'h0);
        host_u.pulse(C_FSTX);
        st(3'h4);
        host_u.pulse(C_CALD);
        st(3'h3);
        host_u.pulse(C_RX);
        st(3'h1);
        host_u.pulse(C_IDLE);
        host_u.pulse(C_RX);
        st(3'h4);
        host_u.pulse(C_CALD);
        host_u.pulse(C_TX);
        st(3'h2);
        host_u.wr(A17, 8'h20);
        host_u.pulse(C_IDLE);
        st(3'h4);
        host_u.pulse(C_CALD);
        host_u.wr(A17, 8'h00);
        host_u.pulse(C_RX);
        host_u.pulse(C_IDLE);
        st(3'h0);
        host_u.pulse(C_CAL);
        st(3'h4);
        // mid-run reset: registers and state fall back, clear channel follows mode 3
        host_u.wr(A16, 8'h05);
        @(negedge ref_clk_i);
        rst_i = 1'b1;
        @(negedge ref_clk_i);
        st(3'h0);
        chk({7'h0, cal_busy}, 8'h00);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        host_u.rd(A16, v);
        chk(v, 8'h30);
        chk({7'h0, ccs}, {7'h0, cc_exp(2'h3, rssi_low, pkt_rx)});
        tally_and_finish();
    end
endmodule
